// *** rtl/sfp_pkg.sv ***
// Constants shared by the flash status/protect/ident device and its host.
// Assumes both ends run on i_clk_sys and see the SPI pins through the interface.
// Operation
// RL1: Ident sends 3 id, length, 16 custom bytes
// RL2: First block byte reports length 10h
// RL3: Custom bytes read-only, default all 00h
// RL4: Ident ignored while a cycle runs
// RL5: Select high ends ident; output released
// RL6: Select high returns device to standby
// RL7: Status readable anytime, repeats while selected
// RL8: Host polls busy before new instruction
// RL9: Busy flag set during write cycles
// RL10: Latch clear rejects all write instructions
// RL11: Guard bits nonvolatile, set by status-write
// RL12: Chip wipe only with all guards zero
// RL13: Locked and pin low makes status read-only
// RL14: Host arms latch, sends opcode plus byte
// RL15: Bits b6,b5,b1,b0 untouched; b6,b5 read zero
// RL16: Select must rise right after data byte
// RL17: Valid status-write starts timed busy cycle
// RL18: Lock clear allows write whatever pin level
// RL19: Lock set, pin high still allows write
// RL20: Hardware lock entered either order, pin exit
// RL21: Arm sets latch; disarm and writes clear
// RL22: Bits MSB first, sampled on rising clock
// RL23: Write commands need whole-byte clock count
// RL24: Fixed one-byte opcodes shared by both ends
package sfp_pkg;
	localparam logic [7:0] SFP_OP_WRITE_ARM = 8'h06;
	localparam logic [7:0] SFP_OP_WRITE_DISARM = 8'h04;
	localparam logic [7:0] SFP_OP_READ_IDENT = 8'h9f;
	localparam logic [7:0] SFP_OP_STATUS_READ = 8'h05;
	localparam logic [7:0] SFP_OP_STATUS_WRITE = 8'h01;
	localparam logic [7:0] SFP_OP_PAGE_PROGRAM = 8'h02;
	localparam logic [7:0] SFP_OP_REGION_WIPE = 8'hd8;
	localparam logic [7:0] SFP_OP_CHIP_WIPE = 8'hc7;
	localparam int SFP_BUSY_BIT = 0;
	localparam int SFP_WEL_BIT = 1;
	localparam int SFP_GUARD_LO = 2;
	localparam int SFP_GUARD_HI = 4;
	localparam int SFP_LOCK_BIT = 7;
	localparam logic [7:0] SFP_STATUS_WR_MASK = 8'h9c;
	localparam logic [7:0] SFP_CUSTOM_LEN = 8'h10;
	localparam logic [7:0] SFP_CUSTOM_DEFAULT = 8'h00;
	localparam int SFP_CUSTOM_BYTES = 16;
	localparam int SFP_IDENT_BYTES = 3 + 1 + SFP_CUSTOM_BYTES;
	// Status update time in ns; the cycle count follows from the clock period
	localparam int SFP_CLK_PERIOD_NS = 100;
	localparam int SFP_T_STATUS_UPDATE_NS = 15000;
	localparam int SFP_STATUS_UPDATE_CYC = (SFP_T_STATUS_UPDATE_NS + SFP_CLK_PERIOD_NS - 1) / SFP_CLK_PERIOD_NS;
	localparam int SFP_PROGRAM_CYC = 64;
	localparam int SFP_ERASE_CYC = 256;
	// Host divider: half period of the link clock in system cycles
	localparam int SFP_SCK_HALF = 4;
	// Avalon register offsets (word addresses)
	localparam logic [1:0] SFP_REG_CMD = 2'h0;
	localparam logic [1:0] SFP_REG_WDATA = 2'h1;
	localparam logic [1:0] SFP_REG_STAT = 2'h2;
	localparam logic [1:0] SFP_REG_RDATA = 2'h3;
endpackage

// *** rtl/sfp_spi_if.sv ***
// SPI pins between the flash device end and the host end.
// Assumes the bench supplies i_clk_sys.
`timescale 1ns/1ps
interface sfp_spi_if;
	logic sel_n;
	logic sck;
	logic mosi;
	logic miso;
	logic miso_oe;
	logic protect_n;
	logic miso_wire;
	assign miso_wire = miso_oe ? miso : 1'b1;
	modport dev(input sel_n, input sck, input mosi, input protect_n, output miso, output miso_oe);
	modport host(output sel_n, output sck, output mosi, input miso_wire);
endinterface

// *** rtl/sfp_sync.sv ***
// Two-flop synchroniser for pins arriving from outside the system clock.
// Assumes a single system clock.
`timescale 1ns/1ps
module sfp_sync #(
	parameter logic RESET_VAL = 1'b0
) (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic i_async,
	output logic o_sync
);
	logic stage1;
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			stage1 <= RESET_VAL;
			o_sync <= RESET_VAL;
		end else begin
			stage1 <= i_async;
			o_sync <= stage1;
		end
	end
endmodule

// *** rtl/sfp_device.sv ***
// Serial flash status, protection and identification logic.
// Assumes the link clock is far slower than i_clk_sys, so sampled edges are seen.
//
// The Avalon-MM interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
module sfp_device
	import sfp_pkg::*;
#(
	parameter int STATUS_UPDATE_CYC = SFP_STATUS_UPDATE_CYC,
	parameter logic [23:0] IDENT_CODE = 24'ha5c3e1
) (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	sfp_spi_if.dev spi,
	input wire logic [8*SFP_CUSTOM_BYTES-1:0] i_custom_bytes,
	input wire logic i_custom_loaded,
	output logic [7:0] o_status,
	output logic o_hw_lock_mode
);
	// IDENT_CODE default is arbitrary
	typedef enum logic [3:0] {
		SFP_ST_IDLE = 4'b0001,
		SFP_ST_OPCODE = 4'b0010,
		SFP_ST_DATA = 4'b0100,
		SFP_ST_SINK = 4'b1000
	} sfp_dev_state_t;

	logic sel_n_s, sck_s, mosi_s, prot_n_s, sck_d, sel_d;
	sfp_sync #(.RESET_VAL(1'b1)) u_sel (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_async(spi.sel_n), .o_sync(sel_n_s));
	sfp_sync #(.RESET_VAL(1'b0)) u_sck (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_async(spi.sck), .o_sync(sck_s));
	sfp_sync #(.RESET_VAL(1'b0)) u_mosi (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_async(spi.mosi), .o_sync(mosi_s));
	sfp_sync #(.RESET_VAL(1'b1)) u_prot (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_async(spi.protect_n),
		.o_sync(prot_n_s));

	logic sck_rise, sck_fall, sel_rise;
	assign sck_rise = !sel_n_s && sck_s && !sck_d; // RL22
	assign sck_fall = !sel_n_s && !sck_s && sck_d;
	assign sel_rise = sel_n_s && !sel_d;

	sfp_dev_state_t state;
	logic [7:0] shift_in, opcode, wr_byte, out_byte, status_snap;
	logic [2:0] bit_cnt;
	logic [5:0] byte_cnt;
	logic whole_byte, wr_got_byte, extra_bits;
	logic busy, write_enable_latch, lock;
	logic [2:0] guard;
	logic [31:0] busy_cnt;
	logic [8*SFP_CUSTOM_BYTES-1:0] custom;

	assign o_hw_lock_mode = lock && !prot_n_s; // RL20
	assign o_status = {lock, 2'b00, guard, write_enable_latch, busy}; // RL15
	assign whole_byte = (bit_cnt == 3'h0); // RL23

	// Pin sampling edges
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			sck_d <= 1'b0;
			sel_d <= 1'b1;
		end else begin
			sck_d <= sck_s;
			sel_d <= sel_n_s;
		end
	end

	// Shift-in, bit and byte counters, frame state
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			state <= SFP_ST_IDLE;
			shift_in <= 8'h00;
			opcode <= 8'h00;
			wr_byte <= 8'h00;
			bit_cnt <= 3'h0;
			byte_cnt <= 6'h00;
			wr_got_byte <= 1'b0;
			extra_bits <= 1'b0;
		end else if (sel_n_s) begin
			state <= SFP_ST_IDLE; // RL6
			bit_cnt <= 3'h0;
			byte_cnt <= 6'h00;
		end else begin
			if (state == SFP_ST_IDLE) begin
				state <= SFP_ST_OPCODE;
				wr_got_byte <= 1'b0;
				extra_bits <= 1'b0;
			end
			if (sck_rise) begin
				shift_in <= {shift_in[6:0], mosi_s}; // RL22
				bit_cnt <= bit_cnt + 3'h1;
				if (state != SFP_ST_OPCODE && wr_got_byte) begin
					extra_bits <= 1'b1; // RL16
				end
				if (bit_cnt == 3'h7) begin
					byte_cnt <= byte_cnt + 6'h01;
					if (state == SFP_ST_OPCODE) begin
						opcode <= {shift_in[6:0], mosi_s}; // RL24
						// RL4
						state <= (busy && {shift_in[6:0], mosi_s} != SFP_OP_STATUS_READ) ? SFP_ST_SINK : SFP_ST_DATA;
					end else if (!wr_got_byte) begin
						wr_byte <= {shift_in[6:0], mosi_s};
						wr_got_byte <= 1'b1;
					end
				end
			end
		end
	end

	// Ident byte positions, counted from the opcode byte
	localparam logic [5:0] ID_LEN_POS = 6'(SFP_IDENT_BYTES - SFP_CUSTOM_BYTES);
	localparam logic [5:0] ID_LAST_POS = 6'(SFP_IDENT_BYTES);

	// Output byte selection for ident and status reads
	always_comb begin
		out_byte = 8'h00;
		if (opcode == SFP_OP_STATUS_READ) begin
			// First bit live, the rest from the copy taken with it
			out_byte = (bit_cnt == 3'h0) ? o_status : status_snap; // RL7
		end else if (byte_cnt < ID_LEN_POS) begin
			case (byte_cnt)
				6'd1: out_byte = IDENT_CODE[23:16];
				6'd2: out_byte = IDENT_CODE[15:8];
				default: out_byte = IDENT_CODE[7:0];
			endcase
		end else if (byte_cnt == ID_LEN_POS) begin
			out_byte = SFP_CUSTOM_LEN; // RL2
		end else if (byte_cnt <= ID_LAST_POS) begin
			// Custom byte 0 sits in the top bits of the vector
			out_byte = custom[8*(SFP_IDENT_BYTES - int'(byte_cnt)) +: 8]; // RL1
		end
	end

	// Status frozen at its first bit, so a cycle ending mid-byte never splits it
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			status_snap <= 8'h00;
		end else if (sck_fall && bit_cnt == 3'h0) begin
			status_snap <= o_status; // RL7
		end
	end

	// Serial output, changes on falling link clock
	always_ff @(posedge i_clk_sys) begin
		if (i_rst || sel_n_s) begin
			spi.miso <= 1'b0;
			spi.miso_oe <= 1'b0; // RL5
		end else if (sck_fall && state == SFP_ST_DATA && byte_cnt != 6'h00 &&
				(opcode == SFP_OP_STATUS_READ || opcode == SFP_OP_READ_IDENT)) begin
			spi.miso <= out_byte[3'h7 - bit_cnt]; // RL1
			spi.miso_oe <= 1'b1;
		end
	end

	// Custom bytes load from i_custom_bytes while i_custom_loaded is high and not busy; no write path from the link
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			custom <= {SFP_CUSTOM_BYTES{SFP_CUSTOM_DEFAULT}}; // RL3
		end else if (i_custom_loaded && !busy) begin
			custom <= i_custom_bytes; // RL3
		end
	end

	// Latch, guard bits, lock bit and the self-timed cycle
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			write_enable_latch <= 1'b0; // RL21
			busy <= 1'b0;
			busy_cnt <= 32'h0;
			guard <= 3'h0; // RL11
			lock <= 1'b0; // RL18
		end else if (busy) begin
			if (busy_cnt <= 32'h1) begin
				busy <= 1'b0; // RL9
				write_enable_latch <= 1'b0; // RL17
			end else begin
				busy_cnt <= busy_cnt - 32'h1;
			end
		end else if (sel_rise && state == SFP_ST_DATA && whole_byte) begin // RL23
			case (opcode)
				SFP_OP_WRITE_ARM: begin
					// A malformed arm is rejected, it does not disarm
					if (byte_cnt == 6'h01) begin
						write_enable_latch <= 1'b1; // RL21
					end
				end
				SFP_OP_WRITE_DISARM: if (byte_cnt == 6'h01) write_enable_latch <= 1'b0; // RL21
				SFP_OP_STATUS_WRITE: begin
					// RL10 RL13 RL16 RL19
					if (write_enable_latch && !o_hw_lock_mode && wr_got_byte && !extra_bits) begin
						lock <= wr_byte[SFP_LOCK_BIT]; // RL11
						guard <= wr_byte[SFP_GUARD_HI:SFP_GUARD_LO]; // RL11
						busy <= 1'b1; // RL17
						busy_cnt <= 32'(STATUS_UPDATE_CYC);
					end
				end
				SFP_OP_CHIP_WIPE: begin
					if (write_enable_latch && byte_cnt == 6'h01) begin
						if (guard == 3'h0) begin // RL12
							busy <= 1'b1;
							busy_cnt <= 32'(SFP_ERASE_CYC);
						end else begin
							write_enable_latch <= 1'b0;
						end
					end
				end
				SFP_OP_PAGE_PROGRAM, SFP_OP_REGION_WIPE: begin
					// Array guarding by region is outside this block; any set guard bit rejects the command, else only the busy timing is modelled
					if (write_enable_latch && byte_cnt >= 6'h04 && guard == 3'h0) begin // RL11
						busy <= 1'b1;
						busy_cnt <= 32'(opcode == SFP_OP_PAGE_PROGRAM ? SFP_PROGRAM_CYC : SFP_ERASE_CYC);
					end else begin
						write_enable_latch <= 1'b0;
					end
				end
				default: write_enable_latch <= write_enable_latch;
			endcase
		end
	end
endmodule

// *** rtl/sfp_host.sv ***
// SPI host controller for the flash status/ident block, driven over Avalon-MM.
// Assumes a single system clock; link clock generated by divider.
`timescale 1ns/1ps
module sfp_host
	import sfp_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_rst,
	sfp_spi_if.host spi,
	input wire logic [1:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest
);
	typedef enum logic [2:0] {
		SFP_H_IDLE = 3'b001,
		SFP_H_SHIFT = 3'b010,
		SFP_H_DONE = 3'b100
	} sfp_host_state_t;

	sfp_host_state_t state;
	logic [7:0] opcode, wdata, tx, rx, rdata;
	logic [4:0] nbytes, byte_idx;
	logic [2:0] bit_idx;
	logic [3:0] div;
	logic miso_s, done, rd_ack;

	sfp_sync #(.RESET_VAL(1'b1)) u_miso (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_async(spi.miso_wire), .o_sync(miso_s));

	// Command register: [7:0] opcode, [12:8] bytes after opcode; start on write
	// Reads wait one cycle, so registered data already stands at the accepting edge
	assign o_avs_waitrequest = (i_avs_write && i_avs_address == SFP_REG_CMD && state != SFP_H_IDLE) ||
		(i_avs_read && !rd_ack);

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			o_avs_readdata <= 32'h0;
			rd_ack <= 1'b0;
		end else begin
			rd_ack <= i_avs_read && !rd_ack;
			if (i_avs_read && !rd_ack) begin
				case (i_avs_address)
					SFP_REG_WDATA: o_avs_readdata <= {24'h0, wdata};
					SFP_REG_STAT: o_avs_readdata <= {30'h0, done, state != SFP_H_IDLE};
					SFP_REG_RDATA: o_avs_readdata <= {24'h0, rdata};
					default: o_avs_readdata <= {19'h0, nbytes, opcode};
				endcase
			end
		end
	end

	// Frame sequencer, bits MSB first, one byte per opcode then data
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			state <= SFP_H_IDLE;
			opcode <= 8'h00;
			wdata <= 8'h00;
			tx <= 8'h00;
			rx <= 8'h00;
			rdata <= 8'h00;
			nbytes <= 5'h0;
			byte_idx <= 5'h0;
			bit_idx <= 3'h0;
			div <= 4'h0;
			done <= 1'b0;
			spi.sel_n <= 1'b1;
			spi.sck <= 1'b0;
			spi.mosi <= 1'b0;
		end else begin
			if (i_avs_write && i_avs_address == SFP_REG_WDATA) begin
				wdata <= i_avs_writedata[7:0];
			end
			case (state)
				SFP_H_IDLE: begin
					if (i_avs_write && i_avs_address == SFP_REG_CMD) begin
						opcode <= i_avs_writedata[7:0]; // RL24
						nbytes <= i_avs_writedata[12:8];
						tx <= i_avs_writedata[7:0];
						byte_idx <= 5'h0;
						bit_idx <= 3'h0;
						div <= 4'h0;
						done <= 1'b0;
						spi.sel_n <= 1'b0; // RL14
						spi.mosi <= i_avs_writedata[7];
						state <= SFP_H_SHIFT;
					end
				end
				SFP_H_SHIFT: begin
					if (div == 4'(SFP_SCK_HALF - 1)) begin
						div <= 4'h0;
						spi.sck <= !spi.sck;
						// Synchronised data lags the device by five cycles, so it is taken late in the bit
						if (spi.sck) begin
							rx <= {rx[6:0], miso_s}; // RL22
							bit_idx <= bit_idx + 3'h1;
							if (bit_idx == 3'h7) begin
								byte_idx <= byte_idx + 5'h1;
								rdata <= {rx[6:0], miso_s};
								if (byte_idx == nbytes) begin
									state <= SFP_H_DONE; // RL16
								end else begin
									tx <= (opcode == SFP_OP_STATUS_WRITE) ? wdata : 8'h00; // RL14
									spi.mosi <= (opcode == SFP_OP_STATUS_WRITE) ? wdata[7] : 1'b0;
								end
							end else begin
								spi.mosi <= tx[3'h6 - bit_idx]; // RL22
							end
						end
					end else begin
						div <= div + 4'h1;
					end
				end
				SFP_H_DONE: begin
					spi.sel_n <= 1'b1; // RL16
					done <= 1'b1;
					state <= SFP_H_IDLE;
				end
				default: state <= SFP_H_IDLE;
			endcase
		end
	end
endmodule

// *** verification/sfp_properties.sv ***
// Link-level properties between the flash device end and the host end.
// Assumes one system clock; instantiated by the bench beside the interface.
`timescale 1ns/1ps
module sfp_properties (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic sel_n,
	input wire logic sck,
	input wire logic mosi,
	input wire logic miso,
	input wire logic miso_oe
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);
	logic [7:0] rises;
	// Rising link edges in the current frame
	always_ff @(posedge i_clk_sys) begin
		if (i_rst || sel_n)
			rises <= 8'h00;
		else if ($rose(sck))
			rises <= rises + 8'h01;
	end
	release_a: assert property (sel_n [*4] |-> !miso_oe) else $error("data driven when idle");
	out_fall_a: assert property (miso_oe && $past(miso_oe) && $changed(miso) |-> !sck)
		else $error("data changed with clock high");
	mosi_hold_a: assert property (sck && $past(sck) |-> $stable(mosi)) else $error("input moved");
	edge_sel_a: assert property ($rose(sck) |-> !sel_n && !$past(sel_n)) else $error("clock unselected");
	half_per_a: assert property ($rose(sck) |-> sck [*4] ##1 !sck) else $error("bad half period");
	whole_byte_a: assert property ($rose(sel_n) |-> rises[2:0] == 3'h0) else $error("partial byte");
	oe_late_a: assert property ($rose(miso_oe) |-> rises >= 8'h08) else $error("output before opcode");
	sel_low_a: assert property ($fell(sel_n) |-> !sck) else $error("select with clock high");
	cover property ($rose(miso_oe));
	cover property ($rose(sel_n) && rises == 8'd16);
	cover property ($rose(sel_n) && rises == 8'd168);
endmodule

// *** verification/serial_flash_status_protect_id_tb.sv ***
// Bench: Avalon host drives the device end over the shared link.
// Assumes sfp_pkg, the interface and both design ends are compiled first.
`timescale 1ns/1ps
module serial_flash_status_protect_id_tb;
	import sfp_pkg::*;
	localparam logic [23:0] IDC = 24'h5a1e37; // Arbitrary code
	logic i_clk_sys = 1'b0;
	logic i_rst = 1'b1;
	logic [1:0] adr = 2'h0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wd = 32'h0;
	logic [31:0] rdat;
	logic wreq;
	logic [7:0] stat;
	logic hwl;
	logic ld = 1'b0;
	logic [127:0] cust = 128'h0;
	logic [7:0] got;
	logic [159:0] idv;
	int miscompares = 0;
	int checked = 0;
	sfp_spi_if sfp_spi_if_i ();
	sfp_device #(.STATUS_UPDATE_CYC(600), .IDENT_CODE(IDC)) sfp_device_i (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
		.spi(sfp_spi_if_i.dev), .i_custom_bytes(cust), .i_custom_loaded(ld), .o_status(stat), .o_hw_lock_mode(hwl));
	sfp_host sfp_host_i (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .spi(sfp_spi_if_i.host), .i_avs_address(adr),
		.i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .o_avs_readdata(rdat), .o_avs_waitrequest(wreq));
	sfp_properties sfp_properties_i (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .sel_n(sfp_spi_if_i.sel_n),
		.sck(sfp_spi_if_i.sck), .mosi(sfp_spi_if_i.mosi), .miso(sfp_spi_if_i.miso), .miso_oe(sfp_spi_if_i.miso_oe));
	always #50 i_clk_sys = ~i_clk_sys;
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wrap_up;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic expire(input logic hit);
		if (hit) begin
			miscompares++;
			wrap_up();
		end
	endtask
	// Request stands until waitrequest is seen low; read data is taken at that edge
	task automatic av(input logic w, input logic [1:0] a, input logic [31:0] d);
		int n;
		n = 0;
		adr <= a;
		wd <= d;
		wr <= w;
		rd <= !w;
		do begin
			@(posedge i_clk_sys);
			n++;
		end while (wreq !== 1'b0 && n < 5000);
		got = rdat[7:0];
		wr <= 1'b0;
		rd <= 1'b0;
		expire(n >= 5000);
		@(posedge i_clk_sys);
	endtask
	task automatic cmd(input logic [7:0] op, input logic [4:0] cnt, input logic [7:0] d);
		int n;
		n = 0;
		av(1'b1, SFP_REG_WDATA, {24'h0, d});
		av(1'b1, SFP_REG_CMD, {19'h0, cnt, op});
		do begin
			av(1'b0, SFP_REG_STAT, 32'h0);
			n++;
		end while (got[0] !== 1'b0 && n < 2000);
		expire(n >= 2000);
		chk("done", {7'h0, got[1]}, 8'h01);
		av(1'b0, SFP_REG_RDATA, 32'h0);
	endtask
	task automatic wsr(input logic [7:0] d);
		cmd(SFP_OP_WRITE_ARM, 5'd0, 8'h00);
		cmd(SFP_OP_STATUS_WRITE, 5'd1, d);
	endtask
	task automatic idle;
		int n;
		n = 0;
		while (stat[0] !== 1'b0 && n < 1000) begin
			@(posedge i_clk_sys);
			n++;
		end
		expire(n >= 1000);
	endtask
	task automatic pin(input logic v, input logic [7:0] exp);
		sfp_spi_if_i.protect_n <= v;
		repeat (4) @(posedge i_clk_sys);
		chk("lock mode", {7'h0, hwl}, exp);
	endtask
	initial begin
		sfp_spi_if_i.protect_n = 1'b1;
		repeat (16) @(posedge i_clk_sys);
		i_rst <= 1'b0;
		@(posedge i_clk_sys);
		chk("reset", stat, 8'h00);
		cmd(SFP_OP_STATUS_READ, 5'd2, 8'h00);
		chk("status read", got, 8'h00);
		cmd(SFP_OP_STATUS_WRITE, 5'd1, 8'h9c);
		chk("unarmed", stat, 8'h00);
		cmd(SFP_OP_WRITE_ARM, 5'd0, 8'h00);
		chk("armed", stat, 8'h02);
		cmd(SFP_OP_WRITE_DISARM, 5'd0, 8'h00);
		chk("disarmed", stat, 8'h00);
		cmd(SFP_OP_WRITE_ARM, 5'd0, 8'h00);
		cmd(SFP_OP_STATUS_WRITE, 5'd2, 8'h9c);
		chk("long write", stat, 8'h02);
		wsr(8'hff);
		chk("busy", {7'h0, stat[0]}, 8'h01);
		cmd(SFP_OP_STATUS_READ, 5'd3, 8'h00);
		chk("busy repeat", got & 8'h03, 8'h03);
		idle();
		chk("written", stat, 8'h9c);
		pin(1'b0, 8'h01);
		wsr(8'h00);
		chk("locked", stat & 8'hfd, 8'h9c);
		pin(1'b1, 8'h00);
		wsr(8'h80);
		idle();
		chk("pin high", stat, 8'h80);
		wsr(8'h00);
		idle();
		pin(1'b0, 8'h00);
		wsr(8'h80);
		idle();
		chk("unlocked", stat, 8'h80);
		pin(1'b0, 8'h01);
		pin(1'b1, 8'h00);
		wsr(8'h1c);
		idle();
		cmd(SFP_OP_WRITE_ARM, 5'd0, 8'h00);
		cmd(SFP_OP_CHIP_WIPE, 5'd0, 8'h00);
		chk("guarded wipe", {7'h0, stat[0]}, 8'h00);
		wsr(8'h00);
		idle();
		cmd(SFP_OP_WRITE_ARM, 5'd0, 8'h00);
		cmd(SFP_OP_CHIP_WIPE, 5'd0, 8'h00);
		chk("wipe busy", {7'h0, stat[0]}, 8'h01);
		cmd(SFP_OP_READ_IDENT, 5'd1, 8'h00);
		chk("ident in cycle", got, 8'hff);
		idle();
		chk("wipe done", stat, 8'h00);
		cmd(SFP_OP_READ_IDENT, 5'd20, 8'h00);
		chk("custom default", got, SFP_CUSTOM_DEFAULT);
		cust <= 128'hf0e1d2c3b4a5968778695a4b3c2d1e0f;
		ld <= 1'b1;
		@(posedge i_clk_sys);
		idv = {IDC, 8'h10, cust};
		for (int k = 1; k <= 20; k++) begin
			cmd(SFP_OP_READ_IDENT, 5'(k), 8'h00);
			chk("ident byte", got, idv[167 - 8 * k -: 8]);
		end
		wrap_up();
	end
endmodule
